// ### src/sram_host_pkg.sv
// Purpose: constants for the async sram host controller
// Assumes: 50 MHz core clock
// Notes: timing counts derived from ns figures
package sram_host_pkg;
  // ==========================================================
  // geometry
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORDS_16 = 262144;
  localparam int unsigned WORDS_8 = 524288;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned READ_CYCLE_NS = 70;
  localparam int unsigned WRITE_PULSE_NS = 60;
  localparam int unsigned BUS_TURN_NS = 30;
  localparam int unsigned RECOVERY_NS = 100;
  localparam int unsigned READ_CYC =
    (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TURN_CYC =
    (BUS_TURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RECOVERY_CYC =
    (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  // ==========================================================
  // states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_TURN,
    ST_RETAIN,
    ST_RECOVER
  } host_state_t;
endpackage : sram_host_pkg

// ### src/sram_pin_drive.sv
// Purpose: maps a request onto sram strobes and lane enables
// Assumes: registered inputs from the sequencer
// Notes: purely combinational
`timescale 1ns/1ps
module sram_pin_drive (
  input wire logic i_wide,
  input wire logic i_sel,
  input wire logic i_rd,
  input wire logic i_wr,
  input wire logic [1:0] i_lanes,
  output logic o_chip_sel_n,
  output logic o_chip_sel_hi,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_low_lane_en_n,
  output logic o_high_lane_en_n
);
  // ==========================================================
  // strobes
  always_comb
  begin
    o_chip_sel_n = ~i_sel;
    o_chip_sel_hi = i_sel;
    o_oe_n = ~i_rd; // [R10]
    o_we_n = ~(i_wr & ~i_rd); // [R20]
    // byte mode leaves lanes low; device ignores them
    o_low_lane_en_n = i_wide ? ~i_lanes[0] : 1'b0; // [R3]
    o_high_lane_en_n = i_wide ? ~i_lanes[1] : 1'b0; // [R4]
  end
endmodule : sram_pin_drive

// ### src/sram_host.sv
// Purpose: host controller for an async word/byte sram
// Assumes: one request at a time, latched in one cycle while o_ready is high
// Notes: width strap only latched while idle
// Operation
// [R1] strap high word mode, low byte mode
// [R2] keep strap steady during any access
// [R3] word mode: lane enables pick bytes
// [R4] byte mode: extra pin is address bit
// [R5] byte mode uses low eight lines only
// [R6] word read of lower byte
// [R7] word read of upper byte
// [R8] word read of full word
// [R9] byte read with extended address
// [R10] output strobe high floats device lines
// [R11] lower byte write during overlap
// [R12] upper byte write during overlap
// [R13] full word write during overlap
// [R14] byte mode write on low lines
// [R15] device floats when deselected or disabled
// [R16] host never fights a driving device
// [R17] deselected device is in standby
// [R18] no access during low supply retention
// [R19] select-controlled write keeps outputs floating
// [R20] write strobe high through every read
// [R21] model updates enabled lanes, reads combinational
`timescale 1ns/1ps
module sram_host #(
  parameter int unsigned ADDR_W = sram_host_pkg::ADDR_W
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_wide_mode,
  input wire logic i_req,
  input wire logic i_we,
  input wire logic [ADDR_W:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [1:0] i_lanes,
  input wire logic i_retain,
  output logic o_ready,
  output logic o_done,
  output logic [15:0] o_rdata,
  output logic o_retaining,
  output logic o_width_select,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_byte_addr_extra,
  output logic o_chip_sel_n,
  output logic o_chip_sel_hi,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_low_lane_en_n,
  output logic o_high_lane_en_n,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe
);
  // ==========================================================
  // state
  sram_host_pkg::host_state_t st_q, st_d;
  logic [sram_host_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic wide_q, wide_d;
  logic sel_q, sel_d;
  logic rd_q, rd_d;
  logic wr_q, wr_d;
  logic [1:0] lanes_q, lanes_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic extra_q, extra_d;
  logic [15:0] wdata_q, wdata_d;
  logic [15:0] rdata_q, rdata_d;
  logic done_q, done_d;

  localparam logic [sram_host_pkg::CNT_W-1:0] READ_N =
    sram_host_pkg::CNT_W'(sram_host_pkg::READ_CYC);
  localparam logic [sram_host_pkg::CNT_W-1:0] WRITE_N =
    sram_host_pkg::CNT_W'(sram_host_pkg::WRITE_CYC);
  localparam logic [sram_host_pkg::CNT_W-1:0] TURN_N =
    sram_host_pkg::CNT_W'(sram_host_pkg::TURN_CYC);
  localparam logic [sram_host_pkg::CNT_W-1:0] REC_N =
    sram_host_pkg::CNT_W'(sram_host_pkg::RECOVERY_CYC);

  // lanes actually used in the chosen width
  function automatic logic [1:0] eff_lanes(input logic wide,
                                           input logic [1:0] ln);
    eff_lanes = wide ? ln : 2'h1; // [R5]
  endfunction : eff_lanes

  // ==========================================================
  // sequencer
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    wide_d = wide_q;
    sel_d = sel_q;
    rd_d = rd_q;
    wr_d = wr_q;
    lanes_d = lanes_q;
    addr_d = addr_q;
    extra_d = extra_q;
    wdata_d = wdata_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    unique case (st_q)
      sram_host_pkg::ST_IDLE:
      begin
        // strap only sampled here, so it stays fixed mid access
        wide_d = i_wide_mode; // [R1] [R2]
        if (i_retain)
        begin
          st_d = sram_host_pkg::ST_RETAIN; // [R17]
        end
        else if (i_req)
        begin
          sel_d = 1'b1;
          lanes_d = eff_lanes(i_wide_mode, i_lanes);
          if (i_wide_mode)
          begin
            addr_d = i_addr[ADDR_W-1:0];
            extra_d = 1'b0; // [R3]
          end
          else
          begin
            // byte address: low bit goes on the extra pin
            addr_d = i_addr[ADDR_W:1];
            extra_d = i_addr[0]; // [R4]
          end
          wdata_d = i_wide_mode ? i_wdata : {8'h00, i_wdata[7:0]};
          if (i_we)
          begin
            wr_d = 1'b1; // [R11] [R12] [R13] [R14]
            cnt_d = WRITE_N;
            st_d = sram_host_pkg::ST_WRITE;
          end
          else
          begin
            rd_d = 1'b1; // [R6] [R7] [R8] [R9]
            cnt_d = READ_N;
            st_d = sram_host_pkg::ST_READ;
          end
        end
      end
      sram_host_pkg::ST_READ:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1)
        begin
          rdata_d[7:0] = lanes_q[0] ? i_dq[7:0] : 8'h00;
          rdata_d[15:8] = lanes_q[1] ? i_dq[15:8] : 8'h00;
          rd_d = 1'b0; // [R10]
          sel_d = 1'b0;
          done_d = 1'b1;
          cnt_d = TURN_N;
          // device needs time to float before we may drive
          st_d = sram_host_pkg::ST_TURN; // [R16]
        end
      end
      sram_host_pkg::ST_WRITE:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1)
        begin
          wr_d = 1'b0;
          sel_d = 1'b0;
          done_d = 1'b1;
          cnt_d = 4'h1;
          st_d = sram_host_pkg::ST_TURN;
        end
      end
      sram_host_pkg::ST_TURN:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1)
        begin
          st_d = sram_host_pkg::ST_IDLE;
        end
      end
      sram_host_pkg::ST_RETAIN:
      begin
        if (!i_retain)
        begin
          cnt_d = REC_N;
          st_d = sram_host_pkg::ST_RECOVER; // [R18]
        end
      end
      sram_host_pkg::ST_RECOVER:
      begin
        cnt_d = cnt_q - 1'b1;
        if (cnt_q == 1)
        begin
          st_d = sram_host_pkg::ST_IDLE;
        end
      end
      default:
      begin
        st_d = sram_host_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_nrst)
    begin
      st_q <= sram_host_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      wide_q <= 1'b1;
      sel_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      lanes_q <= 2'h0;
      addr_q <= '0;
      extra_q <= 1'b0;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      wide_q <= wide_d;
      sel_q <= sel_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      lanes_q <= lanes_d;
      addr_q <= addr_d;
      extra_q <= extra_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // ==========================================================
  // pins
  sram_pin_drive u_pins (
    .i_wide(wide_q),
    .i_sel(sel_q),
    .i_rd(rd_q),
    .i_wr(wr_q),
    .i_lanes(lanes_q),
    .o_chip_sel_n(o_chip_sel_n),
    .o_chip_sel_hi(o_chip_sel_hi),
    .o_oe_n(o_oe_n),
    .o_we_n(o_we_n),
    .o_low_lane_en_n(o_low_lane_en_n),
    .o_high_lane_en_n(o_high_lane_en_n)
  );

  always_comb
  begin
    o_width_select = wide_q;
    o_addr = addr_q;
    o_byte_addr_extra = extra_q;
    o_dq = wdata_q;
    // only drive the lanes being written, never while reading
    o_dq_oe[7:0] = {8{wr_q & lanes_q[0]}}; // [R16] [R19]
    o_dq_oe[15:8] = {8{wr_q & lanes_q[1] & wide_q}}; // [R5]
    o_ready = (st_q == sram_host_pkg::ST_IDLE) & ~i_retain;
    o_done = done_q;
    o_rdata = rdata_q;
    o_retaining = (st_q == sram_host_pkg::ST_RETAIN);
  end
endmodule : sram_host

// ### testbench/sram_host_assertions.sv
// Purpose: pin-level checks on the sram host controller
// Assumes: one clock, sync active-low reset
// Notes: attached by bind to every sram_host
`timescale 1ns/1ps
module sram_host_checker (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic o_ready,
  input wire logic o_done,
  input wire logic o_retaining,
  input wire logic o_width_select,
  input wire logic o_byte_addr_extra,
  input wire logic o_chip_sel_n,
  input wire logic o_chip_sel_hi,
  input wire logic o_oe_n,
  input wire logic o_we_n,
  input wire logic [15:0] o_dq_oe
);
  // ==========================================================
  // sequences and properties
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_nrst);
  sequence s_wr_low;
    (!o_we_n && !o_chip_sel_n && o_chip_sel_hi)[*3];
  endsequence
  sequence s_rd_hold;
    (!o_oe_n && o_we_n && o_dq_oe == 16'h0000)[*4];
  endsequence
  a_write_overlap: assert property ($fell(o_we_n) |-> s_wr_low
    ##1 (o_we_n && o_done)) else $error("write pulse wrong");
  a_read_hold: assert property ($fell(o_oe_n) |-> s_rd_hold ##1
    o_done) else $error("read cycle wrong");
  a_bus_fight: assert property (!o_oe_n |-> o_dq_oe == 16'h0000)
    else $error("host drives during read");
  a_byte_upper_float: assert property (!o_width_select |->
    o_dq_oe[15:8] == 8'h00) else $error("upper lines driven");
  a_retain_desel: assert property (o_retaining |-> o_chip_sel_n &&
    !o_chip_sel_hi && !o_ready) else $error("access in retention");
  a_strap_steady: assert property (!o_chip_sel_n
    && !$past(o_chip_sel_n) |-> $stable(o_width_select))
    else $error("strap moved");
  a_word_extra: assert property (!o_chip_sel_n && o_width_select
    |-> !o_byte_addr_extra) else $error("extra pin set");
  a_done_once: assert property (o_done |=> !o_done)
    else $error("done too long");
endmodule : sram_host_checker
bind sram_host sram_host_checker u_chk (.*);

// ### testbench/sram_dev_model.sv
// Purpose: behavioural word/byte async sram
// Assumes: pins driven by the host controller
// Notes: sparse byte array; writes sampled on clk
`timescale 1ns/1ps
module sram_dev_model (
  input wire logic i_clk,
  input wire logic i_wide,
  input wire logic [17:0] i_addr,
  input wire logic i_extra,
  input wire logic i_sel_n,
  input wire logic i_sel_hi,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_lb_n,
  input wire logic i_ub_n,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_dq_oe
);
  // ==========================================================
  // storage
  logic [7:0] mem [logic [18:0]];
  logic sel;
  logic [18:0] lo;
  logic [18:0] hi;
  logic [1:0] ln;
  assign sel = !i_sel_n && i_sel_hi;
  assign lo = i_wide ? {i_addr, 1'b0} : {i_addr, i_extra};
  assign hi = {i_addr, 1'b1};
  assign ln = i_wide ? ~{i_ub_n, i_lb_n} : 2'h1;
  function automatic logic [7:0] rd(input logic [18:0] a);
    rd = mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rd
  // clock sampling avoids a race with the data release
  always @(posedge i_clk)
  begin
    if (sel && !i_we_n && ln[0])
      mem[lo] = i_dq[7:0];
    if (sel && !i_we_n && ln[1])
      mem[hi] = i_dq[15:8];
  end
  always @*
  begin
    o_dq_oe = 16'h0000;
    o_dq = 16'h0000;
    if (sel && !i_oe_n && i_we_n)
    begin
      o_dq_oe = {{8{ln[1]}}, {8{ln[0]}}};
      o_dq = {rd(hi), rd(lo)};
    end
  end
endmodule : sram_dev_model

// ### testbench/testbench.sv
// Purpose: self-checking bench for the sram host
// Assumes: device model on the far side
// Notes: inputs change on the falling edge
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // signals
  logic clk = 1'b0, nrst = 1'b0, wide = 1'b1, req = 1'b0;
  logic we = 1'b0, retain = 1'b0, o_ready, o_done, o_ret, ws, ex;
  logic sn, sh, oe_n, we_n, lb_n, ub_n;
  logic [18:0] addr = 19'h00000;
  logic [15:0] wd = 16'h0000, rdat, hdq, hoe, ddq, doe, bus;
  logic [15:0] flt = 16'h5A5A;
  logic [17:0] pa;
  logic [1:0] lanes = 2'h0;
  int mismatches = 0, n_tests = 0;
  always #10 clk = ~clk;
  // undriven lines toggle so a stale value never reads back
  always @(posedge clk) flt <= ~flt;
  assign bus = (hdq & hoe) | (ddq & doe) | (flt & ~hoe & ~doe);
  sram_host DUT (.i_core_clk(clk), .i_nrst(nrst), .i_wide_mode(wide),
    .i_req(req), .i_we(we), .i_addr(addr), .i_wdata(wd),
    .i_lanes(lanes), .i_retain(retain), .o_ready(o_ready),
    .o_done(o_done), .o_rdata(rdat), .o_retaining(o_ret),
    .o_width_select(ws), .o_addr(pa), .o_byte_addr_extra(ex),
    .o_chip_sel_n(sn), .o_chip_sel_hi(sh), .o_oe_n(oe_n),
    .o_we_n(we_n), .o_low_lane_en_n(lb_n), .o_high_lane_en_n(ub_n),
    .i_dq(bus), .o_dq(hdq), .o_dq_oe(hoe));
  sram_dev_model u_dev (.i_clk(clk), .i_wide(ws), .i_addr(pa),
    .i_extra(ex), .i_sel_n(sn), .i_sel_hi(sh), .i_oe_n(oe_n),
    .i_we_n(we_n), .i_lb_n(lb_n), .i_ub_n(ub_n), .i_dq(bus),
    .o_dq(ddq), .o_dq_oe(doe));
  // ==========================================================
  // tasks
  task automatic check(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic acc(logic w, logic [18:0] a, logic [15:0] d,
    logic [1:0] l);
    int n;
    n = 0;
    @(negedge clk);
    while (o_ready !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    {req, we, addr, wd, lanes} = {1'b1, w, a, d, l};
    @(negedge clk);
    req = 1'b0;
    n = 0;
    while (o_done !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    check("done", 16'h0001, {15'h0, o_done});
  endtask : acc
  task automatic test_word();
    wide = 1'b1;
    acc(1'b1, 19'h00005, 16'h1234, 2'h3);
    acc(1'b1, 19'h00005, 16'hFFAB, 2'h1);
    acc(1'b1, 19'h00005, 16'hCDFF, 2'h2);
    acc(1'b0, 19'h40005, 16'h0000, 2'h3);
    check("word", 16'hCDAB, rdat);
    acc(1'b0, 19'h00005, 16'h0000, 2'h1);
    check("low", 16'h00AB, rdat);
    acc(1'b0, 19'h00005, 16'h0000, 2'h2);
    check("high", 16'hCD00, rdat);
  endtask : test_word
  task automatic test_byte();
    wide = 1'b0;
    acc(1'b1, 19'h0000A, 16'h5511, 2'h2);
    acc(1'b1, 19'h0000B, 16'h6622, 2'h0);
    acc(1'b0, 19'h0000A, 16'h0000, 2'h0);
    check("byte0", 16'h0011, rdat);
    acc(1'b0, 19'h0000B, 16'h0000, 2'h1);
    check("byte1", 16'h0022, rdat);
    wide = 1'b1;
    acc(1'b0, 19'h00005, 16'h0000, 2'h3);
    check("mixed", 16'h2211, rdat);
  endtask : test_byte
  task automatic test_retain();
    retain = 1'b1;
    {req, we, addr, wd, lanes} = {1'b1, 1'b1, 19'h5, 16'h0, 2'h3};
    repeat (4) @(negedge clk);
    check("ret", 16'h0001, {15'h0, o_ret});
    check("ready", 16'h0000, {15'h0, o_ready});
    check("sel", 16'h0001, {15'h0, sn});
    {req, retain} = 2'b00;
    acc(1'b0, 19'h00005, 16'h0000, 2'h3);
    check("kept", 16'h2211, rdat);
  endtask : test_retain
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  // ==========================================================
  // sequence
  initial
  begin
    #40000;
    mismatches++;
    final_report();
  end
  initial
  begin
    repeat (20) @(negedge clk);
    check("rst", 16'h0001, {15'h0, sn});
    check("rst_oe", 16'h0000, hoe);
    nrst = 1'b1;
    test_word();
    test_byte();
    test_retain();
    final_report();
  end
endmodule : testbench
